// [design/timer_regs.svh]
/*
  Register offsets, field positions, reset values and code points of the
  8-bit timer/counter unit. Assumes a 4-bit byte address on the plain
  register port and 8-bit register data.
*/
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFF_CONTROL_A       4'h0
`define OFF_CONTROL_B       4'h1
`define OFF_COUNT           4'h2
`define OFF_COMPARE_A       4'h3
`define OFF_COMPARE_B       4'h4
`define OFF_FLAGS           4'h5
`define OFF_MASK            4'h6
`define OFF_FLAG_CLEAR      4'h7

// ************************************************************
// field positions
// ************************************************************
`define CTRLA_WAVE_MSB      1
`define CTRLA_WAVE_LSB      0
`define CTRLB_CS_MSB        2
`define CTRLB_CS_LSB        0
`define CTRLB_WAVE2_BIT     3

// ************************************************************
// reset values and counter extremes
// ************************************************************
`define RST_BYTE            8'h00
`define RST_FLAGS           3'h0
`define COUNT_BOTTOM        8'h00
`define COUNT_MAX           8'hff

// ************************************************************
// waveform modes
// ************************************************************
`define WAVE_NORMAL         3'h0
`define WAVE_PHASE_MAX      3'h1
`define WAVE_CTC            3'h2
`define WAVE_FAST_MAX       3'h3
`define WAVE_PHASE_CMPA     3'h5
`define WAVE_FAST_CMPA      3'h7

// ************************************************************
// clock-select codes
// ************************************************************
`define CS_STOP             3'h0
`define CS_DIV1             3'h1
`define CS_DIV_B            3'h2
`define CS_DIV_C            3'h3
`define CS_DIV_D            3'h4
`define CS_DIV_E            3'h5
`define CS_EXT_FALL         3'h6
`define CS_EXT_RISE         3'h7

`endif

// [design/timer_pkg.sv]
/*
  Types shared by the timer/counter unit files.
  Assumes the constants of timer_regs.svh.
*/
package timer_pkg;

  // one register port access as seen in a clock cycle
  typedef struct packed {
    logic       wr;     // write strobe
    logic       rd;     // read strobe
    logic [3:0] addr;   // byte address
    logic [7:0] wdata;  // write data
  } bus_req_t;

  // sticky event flags, same layout in flag, mask and clear registers
  typedef struct packed {
    logic match_b;      // compare match b
    logic match_a;      // compare match a
    logic overflow;     // counter overflow
  } flags_t;

  // counting direction of the phase-correct sequences
  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } dir_t;

endpackage

// [design/tick_select.sv]
/*
  Clock-select stage: prescaler, cleared while stopped, and external pin edge
  detection, producing a one-cycle timer tick. Assumes the pin is
  asynchronous to clk and much slower than it.
*/
`timescale 1ns/1ns
module tick_select
  import timer_pkg::*;
#(
  parameter int PRE_W = 10,    // prescaler width, covers the largest tap
  parameter int DIV_B = 8,     // prescaler taps
  parameter int DIV_C = 64,
  parameter int DIV_D = 256,
  parameter int DIV_E = 1024
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       ext_pin,
  input  wire logic [2:0] sel,
  output logic            tick
);
`include "timer_regs.svh"

  logic [PRE_W-1:0] pre_q;     // prescaler count
  logic             sync1_q;   // pin synchroniser, first stage
  logic             sync2_q;   // pin synchroniser, second stage
  logic             prev_q;    // previous synchronised level

  // tap fires once every div cycles; taps are powers of two
  function automatic logic tap_hit(input logic [PRE_W-1:0] pre, input int div);
    logic [PRE_W-1:0] m;
    m = PRE_W'(div - 1);
    return (pre & m) == m;
  endfunction

  // ************************************************************
  // prescaler, held in reset while stopped so a start is aligned
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (ce) begin
      pre_q <= (sel == `CS_STOP) ? '0 : pre_q + 1'b1;
    end
  end

  // ************************************************************
  // pin synchroniser; only the second stage feeds the edge logic
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else if (ce) begin
      sync1_q <= ext_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ************************************************************
  // source and edge choice
  // ************************************************************
  always_comb begin
    unique case (sel)
      `CS_STOP:     tick = 1'b0;                  // R8
      `CS_DIV1:     tick = 1'b1;
      `CS_DIV_B:    tick = tap_hit(pre_q, DIV_B); // R19
      `CS_DIV_C:    tick = tap_hit(pre_q, DIV_C);
      `CS_DIV_D:    tick = tap_hit(pre_q, DIV_D);
      `CS_DIV_E:    tick = tap_hit(pre_q, DIV_E);
      `CS_EXT_FALL: tick = prev_q & ~sync2_q;     // R6
      `CS_EXT_RISE: tick = sync2_q & ~prev_q;     // R6
    endcase
  end

endmodule

// [design/timer_unit.sv]
/*
  Counting core of an 8-bit timer/counter: count register, two compare
  registers, clock select, waveform sequences and three flagged events.
  Assumes a register master on CORE_CLK with one-cycle strobes, and an
  interrupt controller that pulses INT_ACK when it services an event.
*/
// Functional notes
// R1 - zero is bottom, flagged while held
// R2 - all ones is maximum, flagged when reached
// R3 - top is maximum or compare a, by mode
// R4 - count and both compares are 8-bit registers
// R5 - overflow, match a, match b flagged and masked
// R6 - tick from prescaler or chosen pin edge
// R7 - three-bit clock select in control b
// R8 - select zero stops all tick activity
// R9 - count register always readable and writable
// R10 - register write beats clear or count
// R11 - each tick clears, increments or decrements
// R12 - step by one; clear zeroes all bits
// R13 - mode: two bits in a, one in b
// R14 - overflow flag set where mode defines
// R15 - compares checked continuously in every mode
// R16 - match sets flag; unmasked raises interrupt
// R17 - flag one tick late; ack or one clears
// R18 - count write blocks next tick's match
// R19 - nonzero selects choose taps or pin edges
`timescale 1ns/1ns
module timer_unit
  import timer_pkg::*;
#(
  parameter int PRE_W = 10,   // prescaler width
  parameter int DIV_B = 8,    // prescaler taps
  parameter int DIV_C = 64,
  parameter int DIV_D = 256,
  parameter int DIV_E = 1024
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RSTN,
  input  wire logic       CE,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  output logic      [7:0] RDATA,
  input  wire logic       EXTERNAL_COUNT_PIN,
  input  wire logic [2:0] INT_ACK,
  output logic            IRQ,
  output logic            AT_BOTTOM,
  output logic            AT_MAX,
  output logic            AT_TOP
);
`include "timer_regs.svh"

  // ************************************************************
  // declarations
  // ************************************************************
  bus_req_t   req;            // current register access
  logic [1:0] ctrl_a_q;       // low waveform bits
  logic [3:0] ctrl_b_q;       // high waveform bit and clock select
  logic [7:0] count_q;        // count register
  logic [7:0] count_d;
  logic [7:0] cmp_a_q;        // compare value a
  logic [7:0] cmp_b_q;        // compare value b
  flags_t     flags_q;        // sticky event flags
  flags_t     mask_q;         // interrupt enables
  flags_t     set_ev;         // events of this cycle
  flags_t     clr_ev;         // clears of this cycle
  dir_t       dir_q;          // phase-correct direction
  dir_t       dir_d;
  logic       block_q;        // match blocked for the next tick
  logic [7:0] rdata_q;        // read data, one cycle after the strobe
  logic       bottom_q;       // registered indications
  logic       max_q;
  logic       top_q;
  logic [2:0] wave;           // waveform mode
  logic [2:0] cs;             // clock select
  logic       tick;           // timer tick from the select stage
  logic       adv;            // tick that may act on the counter
  logic       cnt_wr;         // register write to the count
  logic [7:0] top_val;        // highest value of the sequence
  logic       at_top;
  logic       eq_a;           // comparator outputs
  logic       eq_b;
  logic       ovf_ev;         // overflow event of this tick

  // address match used by every write and flag-clear decode
  function automatic logic hit(input bus_req_t r, input logic [3:0] off);
    return r.addr == off;
  endfunction

  assign req    = '{wr: WR_STB, rd: RD_STB, addr: ADDR, wdata: WDATA};
  assign wave   = {ctrl_b_q[`CTRLB_WAVE2_BIT], ctrl_a_q};                    // R13
  assign cs     = ctrl_b_q[`CTRLB_CS_MSB:`CTRLB_CS_LSB];                     // R7
  assign cnt_wr = CE & req.wr & hit(req, `OFF_COUNT);                        // R9
  assign adv    = CE & tick;                                                 // R8

  // top comes from compare a in ctc and in the two compare-topped pwm modes
  assign top_val = (wave == `WAVE_FAST_CMPA || wave == `WAVE_PHASE_CMPA ||
                    wave == `WAVE_CTC) ? cmp_a_q : `COUNT_MAX;               // R3
  assign at_top  = count_q == top_val;

  // comparators run whatever the mode or tick source
  assign eq_a = count_q == cmp_a_q;                                          // R15
  assign eq_b = count_q == cmp_b_q;                                          // R15

  // ************************************************************
  // clock select stage
  // ************************************************************
  tick_select #(
    .PRE_W (PRE_W),
    .DIV_B (DIV_B),
    .DIV_C (DIV_C),
    .DIV_D (DIV_D),
    .DIV_E (DIV_E)
  ) u_tick (
    .clk     (CORE_CLK),
    .rst_n   (RSTN),
    .ce      (CE),
    .ext_pin (EXTERNAL_COUNT_PIN),
    .sel     (cs),
    .tick    (tick)
  );

  // ************************************************************
  // control and compare registers
  // ************************************************************
  // plain stores; reserved bits are not kept and read back as zero
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_a_q <= 2'h0;
      ctrl_b_q <= 4'h0;
      cmp_a_q  <= `RST_BYTE;
      cmp_b_q  <= `RST_BYTE;
      mask_q   <= `RST_FLAGS;
    end else if (CE && req.wr) begin
      if (hit(req, `OFF_CONTROL_A)) begin
        ctrl_a_q <= req.wdata[`CTRLA_WAVE_MSB:`CTRLA_WAVE_LSB];
      end
      if (hit(req, `OFF_CONTROL_B)) begin
        ctrl_b_q <= req.wdata[3:0];
      end
      if (hit(req, `OFF_COMPARE_A)) begin
        cmp_a_q <= req.wdata;                                                // R4
      end
      if (hit(req, `OFF_COMPARE_B)) begin
        cmp_b_q <= req.wdata;                                                // R4
      end
      if (hit(req, `OFF_MASK)) begin
        mask_q <= req.wdata[2:0];                                            // R5
      end
    end
  end

  // ************************************************************
  // next count and direction
  // ************************************************************
  always_comb begin
    count_d = count_q;
    dir_d   = dir_q;
    ovf_ev  = 1'b0;
    if (cnt_wr) begin
      count_d = req.wdata;                                                   // R10
    end else if (adv) begin                                                  // R11
      case (wave)
        `WAVE_CTC: begin
          // clear on top; overflow only if the count really wraps at max
          count_d = at_top ? `COUNT_BOTTOM : count_q + 8'h01;                // R12
          ovf_ev  = count_q == `COUNT_MAX;                                   // R14
        end
        `WAVE_FAST_MAX, `WAVE_FAST_CMPA: begin
          count_d = at_top ? `COUNT_BOTTOM : count_q + 8'h01;                // R12
          ovf_ev  = at_top;                                                  // R14
        end
        `WAVE_PHASE_MAX, `WAVE_PHASE_CMPA: begin
          if (dir_q == DIR_UP) begin
            // a top of zero would turn at bottom; stay upward there
            if (at_top && count_q != `COUNT_BOTTOM) begin
              dir_d   = DIR_DOWN;
              count_d = count_q - 8'h01;                                     // R12
            end else begin
              count_d = count_q + 8'h01;
            end
          end else if (count_q == `COUNT_BOTTOM) begin
            dir_d   = DIR_UP;
            count_d = count_q + 8'h01;
            ovf_ev  = 1'b1;                                                  // R14
          end else begin
            count_d = count_q - 8'h01;                                       // R12
          end
        end
        default: begin
          // normal, and the reserved codes behave like it
          count_d = count_q + 8'h01;                                         // R12
          ovf_ev  = count_q == `COUNT_MAX;                                   // R14
        end
      endcase
    end
  end

  // ************************************************************
  // counter state
  // ************************************************************
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_q  <= `RST_BYTE;
      dir_q    <= DIR_UP;
      bottom_q <= 1'b1;
      max_q    <= 1'b0;
      top_q    <= 1'b0;
    end else if (CE) begin
      count_q  <= count_d;
      // leaving a phase mode resets the direction to up
      dir_q    <= (wave[0] && !wave[1]) ? dir_d : DIR_UP;
      bottom_q <= count_d == `COUNT_BOTTOM;                                  // R1
      max_q    <= count_d == `COUNT_MAX;                                     // R2
      top_q    <= count_d == top_val;                                        // R3
    end
  end

  // ************************************************************
  // compare blocking after a count write
  // ************************************************************
  // lets software preload compare = count without a spurious match
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;                                                       // R18
    end else if (adv) begin
      block_q <= 1'b0;
    end
  end

  // ************************************************************
  // event flags
  // ************************************************************
  // the flag lands on the tick after equality because it is sampled
  // on the tick that moves the counter away from the compared value
  always_comb begin
    set_ev.overflow = ovf_ev;                                                // R14
    set_ev.match_a  = adv & ~cnt_wr & ~block_q & eq_a;                       // R16 R17 R18
    set_ev.match_b  = adv & ~cnt_wr & ~block_q & eq_b;                       // R16 R17 R18
    clr_ev          = INT_ACK;                                               // R17
    if (req.wr && (hit(req, `OFF_FLAGS) || hit(req, `OFF_FLAG_CLEAR))) begin
      clr_ev = clr_ev | req.wdata[2:0];                                      // R17
    end
  end

  // a set in the same cycle as its clear wins
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      flags_q <= `RST_FLAGS;
    end else if (CE) begin
      flags_q <= (flags_q & ~clr_ev) | set_ev;                               // R5
    end
  end

  assign IRQ = |(flags_q & mask_q);                                          // R16

  // ************************************************************
  // read port
  // ************************************************************
  // data stand only in the cycle after the strobe; otherwise zero
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 8'h00;
    end else if (CE) begin
      rdata_q <= 8'h00;
      if (req.rd) begin
        unique case (req.addr)
          `OFF_CONTROL_A: rdata_q <= {6'h00, ctrl_a_q};
          `OFF_CONTROL_B: rdata_q <= {4'h0, ctrl_b_q};
          `OFF_COUNT:     rdata_q <= count_q;                                // R9
          `OFF_COMPARE_A: rdata_q <= cmp_a_q;
          `OFF_COMPARE_B: rdata_q <= cmp_b_q;
          `OFF_FLAGS:     rdata_q <= {5'h00, flags_q};                       // R5
          `OFF_MASK:      rdata_q <= {5'h00, mask_q};
          default:        rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign RDATA     = rdata_q;
  assign AT_BOTTOM = bottom_q;
  assign AT_MAX    = max_q;
  assign AT_TOP    = top_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  a_bottom_tracks: assert property (AT_BOTTOM == (count_q == 8'h00)) // R1
    else $error("bottom indication disagrees with count");
  a_max_tracks: assert property (AT_MAX == (count_q == 8'hff)) // R2
    else $error("max indication disagrees with count");
  a_ctc_top_clear: assert property (CE && adv && !cnt_wr && wave == 3'h2 && count_q == cmp_a_q // R3
    |=> count_q == 8'h00)
    else $error("ctc did not clear at compare a top");
  a_stop_holds: assert property (CE && cs == 3'h0 && !cnt_wr |=> $stable(count_q)) // R8
    else $error("stopped timer changed its count");
  a_write_wins: assert property (cnt_wr |=> count_q == $past(WDATA)) // R10
    else $error("count write lost to a tick");
  a_normal_step: assert property (adv && !cnt_wr && wave == 3'h0 // R12
    |=> count_q == $past(count_q) + 8'h01)
    else $error("normal mode did not step by one");
  a_normal_ovf: assert property (adv && !cnt_wr && wave == 3'h0 && count_q == 8'hff // R14
    |=> flags_q.overflow && count_q == 8'h00)
    else $error("normal wrap did not flag overflow");
  a_match_sets: assert property (adv && !cnt_wr && !block_q && eq_a |=> flags_q.match_a) // R17
    else $error("match a flag not set one tick late");
  a_match_block: assert property (cnt_wr ##1 (adv && !cnt_wr && !flags_q.match_b)[*1] // R18
    |=> !flags_q.match_b)
    else $error("match b flag set on a blocked tick");
  a_flag_clear: assert property (CE && req.wr && hit(req, 4'h7) && req.wdata[1] && !set_ev.match_a // R17
    |=> !flags_q.match_a)
    else $error("write of one did not clear match a");
  a_irq_mask: assert property (flags_q.match_a && !mask_q.match_a && flags_q.overflow == 1'b0 // R16
    && flags_q.match_b == 1'b0 |-> !IRQ)
    else $error("masked flag raised the interrupt");

  c_overflow: cover property (adv && ovf_ev);
  c_phase_turn: cover property (dir_q == DIR_UP ##1 dir_q == DIR_DOWN);
  c_blocked_match: cover property (block_q && adv && eq_a);
  c_ext_tick: cover property (adv && cs == 3'h7);

endmodule

// [tb/cpu_master.sv]
/*
  register master model standing on the cpu side of the timer unit.
  assumes one clock and a slave that answers a read one cycle later.
*/
`timescale 1ns/1ns
module cpu_master (
  input  wire logic       clk,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_stb,
  output logic            rd_stb,
  input  wire logic [7:0] rdata
);
  // ************************************************************
  // bus cycles
  // ************************************************************
  // quiet bus at time zero
  initial begin
    addr   = 4'h0;
    wdata  = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  // one write cycle; the gap cycle after it avoids a double assignment
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata  <= ~d;  // released data no longer shows the last value
  endtask

  // one read cycle; data taken mid-cycle after the strobe, where it settles
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// [tb/timer_unit_tb_top.sv]
/*
  self-checking bench of the timer unit: scenario tasks over the register
  port. assumes short prescaler taps so each run stays brief.
*/
`timescale 1ns/1ns
`include "timer_regs.svh"
module timer_unit_tb_top;
  logic       clk;          // 100 mhz core clock
  logic       rst_n;        // async reset, active low
  logic       ce;           // clock enable
  logic       pin;          // external count input
  logic [2:0] ack;          // interrupt serviced pulses
  logic [3:0] addr;         // register address
  logic [7:0] wdata;        // write data
  logic       wr_stb;       // write strobe
  logic       rd_stb;       // read strobe
  logic [7:0] rdata;        // read data
  logic       irq;          // level interrupt
  logic       at_bottom;    // counter at zero
  logic       at_max;       // counter at all ones
  logic       at_top;       // counter at top
  int         miscompares;  // mismatches seen
  int         compares;     // comparisons made
  logic [7:0] v;            // last value read

  // ************************************************************
  // instances
  // ************************************************************
  // short taps keep the divided runs under a hundred cycles
  timer_unit #(.PRE_W(4), .DIV_B(2), .DIV_C(4), .DIV_D(8), .DIV_E(16)) u_timer_unit (
    .CORE_CLK(clk), .RSTN(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata), .EXTERNAL_COUNT_PIN(pin), .INT_ACK(ack), .IRQ(irq),
    .AT_BOTTOM(at_bottom), .AT_MAX(at_max), .AT_TOP(at_top));
  cpu_master u_cpu_master (
    .clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));

  // ************************************************************
  // helpers
  // ************************************************************
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // an unknown value fails the range test as well
  task automatic in_range(input string what, input logic [7:0] lo, input logic [7:0] hi);
    check(what, {7'h00, (v >= lo && v <= hi)}, 8'h01);
  endtask

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    u_cpu_master.wr(a, d);
  endtask

  task automatic reg_is(input string what, input logic [3:0] a, input logic [7:0] exp);
    u_cpu_master.rd(a, v);
    check(what, v, exp);
  endtask

  // start the tick source, let it run, then stop it keeping the mode bit
  task automatic run(input logic [7:0] cb, input int n);
    w(`OFF_CONTROL_B, cb);
    repeat (n) @(posedge clk);
    w(`OFF_CONTROL_B, cb & 8'h08);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    check("bottom", {7'h00, at_bottom}, 8'h01);
    check("irq", {7'h00, irq}, 8'h00);
    for (int i = 0; i < 10; i++) begin
      reg_is("reset reg", i[3:0], 8'h00);
    end
  endtask

  task automatic t_count_access();
    w(`OFF_COUNT, 8'hab);
    reg_is("count", `OFF_COUNT, 8'hab);
    repeat (20) @(posedge clk);
    reg_is("stopped", `OFF_COUNT, 8'hab);
    @(posedge clk) ce <= 1'b0;
    w(`OFF_COUNT, 8'h55);  // frozen block ignores the strobe
    @(posedge clk) ce <= 1'b1;
    reg_is("ce low", `OFF_COUNT, 8'hab);
    w(`OFF_COUNT, 8'hff);
    repeat (2) @(negedge clk);
    check("max", {6'h00, at_max, at_bottom}, 8'h02);
    w(`OFF_COUNT, 8'h00);
    repeat (2) @(negedge clk);
    check("bottom", {6'h00, at_max, at_bottom}, 8'h01);
    w(`OFF_COMPARE_A, 8'h80);
    w(`OFF_COMPARE_B, 8'h40);
    w(`OFF_CONTROL_B, 8'h01);
    w(`OFF_COUNT, 8'h40);  // equals compare b while ticking; the next tick must not match
    w(`OFF_CONTROL_B, 8'h00);
    u_cpu_master.rd(`OFF_COUNT, v);
    in_range("write wins", 8'h40, 8'h43);
  endtask

  task automatic t_overflow();
    w(`OFF_MASK, 8'h01);
    w(`OFF_COUNT, 8'hfe);
    run(8'h01, 10);
    reg_is("ovf flag", `OFF_FLAGS, 8'h01);
    check("irq", {7'h00, irq}, 8'h01);
    w(`OFF_MASK, 8'h00);
    @(negedge clk);
    check("masked", {7'h00, irq}, 8'h00);
    w(`OFF_MASK, 8'h01);
    @(posedge clk) ack <= 3'h1;
    @(posedge clk) ack <= 3'h0;
    @(negedge clk);
    check("acked", {7'h00, irq}, 8'h00);
    reg_is("acked", `OFF_FLAGS, 8'h00);
  endtask

  task automatic t_match();
    w(`OFF_COUNT, 8'h10);
    w(`OFF_COMPARE_A, 8'h12);
    w(`OFF_COMPARE_B, 8'h14);
    w(`OFF_MASK, 8'h06);
    run(8'h01, 10);
    reg_is("match", `OFF_FLAGS, 8'h06);
    check("irq", {7'h00, irq}, 8'h01);
    w(`OFF_FLAG_CLEAR, 8'h02);
    reg_is("clear a", `OFF_FLAGS, 8'h04);
    w(`OFF_FLAGS, 8'h04);
    reg_is("clear b", `OFF_FLAGS, 8'h00);
    check("irq", {7'h00, irq}, 8'h00);
    reg_is("mask", `OFF_MASK, 8'h06);
    w(`OFF_COMPARE_A, 8'h20);
    w(`OFF_COUNT, 8'h20);
    run(8'h01, 10);
    reg_is("blocked", `OFF_FLAGS, 8'h00);
  endtask

  task automatic t_modes();
    w(`OFF_CONTROL_A, 8'h02);
    w(`OFF_COMPARE_A, 8'h05);
    w(`OFF_COUNT, 8'h00);
    run(8'h01, 40);
    u_cpu_master.rd(`OFF_COUNT, v);
    in_range("ctc", 8'h00, 8'h05);
    w(`OFF_COUNT, 8'h05);
    @(negedge clk);
    check("top", {7'h00, at_top}, 8'h01);
    w(`OFF_CONTROL_A, 8'h01);
    w(`OFF_COUNT, 8'hfe);
    run(8'h01, 10);
    u_cpu_master.rd(`OFF_COUNT, v);
    in_range("down", 8'hf0, 8'hfe);
    w(`OFF_COMPARE_A, 8'h08);
    w(`OFF_COUNT, 8'h00);
    run(8'h09, 40);
    u_cpu_master.rd(`OFF_COUNT, v);
    in_range("phase a", 8'h00, 8'h08);
    w(`OFF_CONTROL_A, 8'h03);  // fast sequence topped by compare a
    w(`OFF_COUNT, 8'h00);
    run(8'h09, 40);
    u_cpu_master.rd(`OFF_COUNT, v);
    in_range("fast a", 8'h00, 8'h08);
    w(`OFF_CONTROL_B, 8'h00);
    w(`OFF_CONTROL_A, 8'h00);
    w(`OFF_FLAG_CLEAR, 8'h07);
  endtask

  task automatic t_sources();
    int e;
    w(`OFF_MASK, 8'h00);  // matches now land with every source masked
    for (int i = 1; i <= 5; i++) begin
      e = 66 >> (i - 1);  // ticks across the run window
      w(`OFF_COUNT, 8'h00);
      run(8'(i), 64);
      u_cpu_master.rd(`OFF_COUNT, v);
      in_range("divided", 8'(e - 2), 8'(e + 2));
    end
    check("all masked", {7'h00, irq}, 8'h00);
    for (int c = 6; c <= 7; c++) begin
      w(`OFF_COUNT, 8'h00);
      w(`OFF_CONTROL_B, 8'(c));
      repeat (3) begin
        @(posedge clk) pin <= 1'b1;
        repeat (5) @(posedge clk);
        pin <= 1'b0;
        repeat (5) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      w(`OFF_CONTROL_B, 8'h00);
      reg_is("pin edges", `OFF_COUNT, 8'h03);
    end
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  // reset for three cycles, then the scenarios in turn
  initial begin
    miscompares = 0;
    compares    = 0;
    rst_n       = 1'b0;
    ce          = 1'b1;
    pin         = 1'b0;
    ack         = 3'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_count_access();
    t_overflow();
    t_match();
    t_modes();
    t_sources();
    tally_and_finish();
  end

  // the scenarios take under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
